// ---- verilog/emcd_pin_mux.sv ----
// Purpose: Pin configuration register and chip-enable decode for the external bus
// Assumes: SFR strobes, memory control and port latches come from sys_clk logic
// Notes:   Chip enables are active low; outputs are registered one cycle after strobe
//
// Contract
// - Upper field picks how many port pins carry A16 upward to A21.
// - Block per chip enable is 32k,128k,256k,512k,1M,2M, else 4M.
// - Code 000 decodes chip enables on 32kB boundaries.
// - Enable n selects the n-th block from zero; 4M code decodes only 0-3.
// - Each chip enable can be program-only or program/data per control bits.
// - Program/data enable covering a data area disables peripheral enables 0-3.
// - Lower field codes 100..111 put enables 0..3 on port four bits 0..3.
// - Combined select bit makes enable n also peripheral n, peripheral n off.
// - Enables 4-7 reach pins by the second port config lower field.
// - Peripheral block size comes from second port config bits 5..3.
// - Config writes only land after the timed-access unlock.
// - Config register resets to all ones.
// - Assigned pins ignore port data latch writes.
`timescale 1ns/100ps
`include "emcd_cfg.svh"
module emcd_pin_mux (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   // Special function register access
   input  wire logic        cfgWr,
   input  wire logic [7:0]  cfgWrData,
   input  wire logic        taWr,
   input  wire logic [7:0]  taWrData,
   output logic      [7:0]  cfgRdData_q,
   output logic             taOpen_q,
   // Related control registers
   input  wire logic [7:0]  memCtrl,
   input  wire logic [7:0]  memCtrlTwo,
   input  wire logic [7:0]  secondPortCfg,
   // Core memory cycle
   input  wire logic        busStrobe,
   input  wire logic        busIsData,
   input  wire logic [23:0] busAddr,
   // Port data latches
   input  wire logic [7:0]  portFourLatch,
   input  wire logic [5:0]  portSixLatch,
   // Pins
   output logic      [7:0]  portFourOut_q,
   output logic      [7:0]  portFourLock_q,
   output logic      [5:0]  portSixOut_q,
   output logic      [5:0]  portSixLock_q,
   output logic      [7:0]  progCe_n_q,
   output logic      [3:0]  periphCe_n_q
);

   localparam logic [1:0] TA_CYC = 2'(`EMCD_TA_WINDOW_CYC);

   function automatic logic [2:0] ceCount(input logic [2:0] code);
      case (code)
         3'b100:  ceCount = 3'h1;
         3'b101:  ceCount = 3'h2;
         3'b110:  ceCount = 3'h3;
         3'b111:  ceCount = 3'h4;
         default: ceCount = 3'h0;
      endcase
   endfunction : ceCount

   function automatic logic [3:0] pinMask(input logic [2:0] count);
      pinMask = 4'((5'h01 << count) - 5'h01);
   endfunction : pinMask

   function automatic logic [5:0] addrMask(input logic [2:0] code);
      case (code)
         3'b110, 3'b111: addrMask = 6'h3f;
         default:        addrMask = 6'((7'h01 << code) - 7'h01);
      endcase
   endfunction : addrMask

   // Reset release
   logic rstSync1_q;
   logic rstSync2_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end
   logic rstN;
   assign rstN = rstSync2_q;

   // Timed-access unlock: key one then key two, then a short write window
   emcd_pkg::emcd_ta_type taState_q;
   logic [1:0]            taCnt_q;
   logic                  cfgAccept;
   assign cfgAccept = cfgWr && (taState_q == emcd_pkg::TA_OPEN);

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         taState_q <= emcd_pkg::TA_IDLE;
         taCnt_q   <= 2'h0;
      end else begin
         case (taState_q)
            emcd_pkg::TA_IDLE: begin
               if (taWr && taWrData == `EMCD_TA_KEY_ONE) begin
                  taState_q <= emcd_pkg::TA_ARMED;
                  taCnt_q   <= TA_CYC;
               end
            end
            emcd_pkg::TA_ARMED: begin
               if (taWr && taWrData == `EMCD_TA_KEY_TWO) begin
                  taState_q <= emcd_pkg::TA_OPEN;
                  taCnt_q   <= TA_CYC;
               end else if (taCnt_q == 2'h0 || taWr) begin
                  taState_q <= emcd_pkg::TA_IDLE;
               end else begin
                  taCnt_q <= taCnt_q - 2'h1;
               end
            end
            emcd_pkg::TA_OPEN: begin
               // One write per unlock; the window also closes by itself
               if (cfgWr || taCnt_q == 2'h0) begin
                  taState_q <= emcd_pkg::TA_IDLE;
               end else begin
                  taCnt_q <= taCnt_q - 2'h1;
               end
            end
            default: taState_q <= emcd_pkg::TA_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         taOpen_q <= 1'b0;
      end else begin
         taOpen_q <= (taState_q == emcd_pkg::TA_OPEN) && !cfgWr;
      end
   end

   // Pin configuration register
   logic [7:0] cfg_q;
   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         cfg_q <= `EMCD_CFG_RESET;
      end else if (cfgAccept) begin
         cfg_q <= cfgWrData;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         cfgRdData_q <= `EMCD_CFG_RESET;
      end else begin
         cfgRdData_q <= cfgAccept ? cfgWrData : cfg_q;
      end
   end

   logic [2:0] addrCode;
   logic [2:0] ceCode;
   assign addrCode = cfg_q[`EMCD_ADDR_MSB:`EMCD_ADDR_LSB];
   assign ceCode   = cfg_q[`EMCD_CE_MSB:`EMCD_CE_LSB];

   // Program and peripheral block decoders
   emcd_dec_if progDec ();
   emcd_dec_if periDec ();
   assign progDec.addr     = busAddr;
   assign progDec.sizeCode = addrCode;
   assign periDec.addr     = busAddr;
   assign periDec.sizeCode = secondPortCfg[5:3];

   emcd_block_decode progDecode (
      .dec (progDec.decoder)
   );
   emcd_block_decode periDecode (
      .dec (periDec.decoder)
   );

   // Chip-enable selection for one memory cycle
   logic [7:0] progSel;
   logic [3:0] periSel;
   logic       dataCovered;
   always_comb begin
      // Program fetch hits any enable; data access only program/data ones
      progSel     = busIsData ? (progDec.hit & memCtrlTwo) : progDec.hit;
      dataCovered = busIsData && |(progDec.hit & memCtrlTwo);
      periSel     = 4'h0;
      if (busIsData && !dataCovered) begin
         periSel = periDec.hit[3:0];
      end
      // Combined enables take over the peripheral role on their own pin
      progSel[3:0] = progSel[3:0] | (periSel & memCtrl[3:0]);
      periSel      = periSel & ~memCtrl[3:0];
      if (!busStrobe) begin
         progSel = 8'h00;
         periSel = 4'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         progCe_n_q   <= 8'hff;
         periphCe_n_q <= 4'hf;
      end else begin
         progCe_n_q   <= ~progSel;
         periphCe_n_q <= ~periSel;
      end
   end

   // Pin assignment and lockout
   logic [3:0] ceLoMask;
   logic [3:0] ceHiMask;
   logic [5:0] aMask;
   assign ceLoMask = pinMask(ceCount(ceCode));
   assign ceHiMask = pinMask(ceCount(secondPortCfg[2:0]));
   assign aMask    = addrMask(addrCode);

   logic [7:0] portFourNext;
   logic [5:0] portSixNext;
   always_comb begin
      portFourNext = portFourLatch;
      portSixNext  = portSixLatch;
      for (int i = 0; i < 4; i++) begin
         if (ceLoMask[i]) begin
            portFourNext[i] = ~progSel[i];
         end
         if (ceHiMask[i]) begin
            portSixNext[i] = ~progSel[i + 4];
         end
         if (aMask[i]) begin
            portFourNext[i + 4] = busAddr[16 + i];
         end
      end
      if (aMask[4]) begin
         portSixNext[4] = busAddr[20];
      end
      if (aMask[5]) begin
         portSixNext[5] = busAddr[21];
      end
   end

   always_ff @(posedge sys_clk or negedge rstN) begin
      if (!rstN) begin
         portFourOut_q  <= 8'hff;
         portSixOut_q   <= 6'h3f;
         portFourLock_q <= 8'hff;
         portSixLock_q  <= 6'h3f;
      end else begin
         portFourOut_q  <= portFourNext;
         portSixOut_q   <= portSixNext;
         portFourLock_q <= {aMask[3:0], ceLoMask};
         portSixLock_q  <= {aMask[5:4], ceHiMask};
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstN);

   sequence unlockSeq;
      taWr && taWrData == `EMCD_TA_KEY_ONE && taState_q == emcd_pkg::TA_IDLE
         ##1 taWr && taWrData == `EMCD_TA_KEY_TWO;
   endsequence

   ta_locked_write_a: assert property (
      cfgWr && taState_q != emcd_pkg::TA_OPEN |=> $stable(cfg_q))
      else $error("config changed without unlock");
   ta_unlock_write_a: assert property (
      unlockSeq ##1 cfgWr |=> cfg_q == $past(cfgWrData))
      else $error("unlocked write lost");
   cfg_reset_a: assert property (
      $rose(rstN) |-> cfg_q == 8'hff)
      else $error("config not all ones after reset");
   ce_pin_count_a: assert property (
      ceCode == 3'b110 |=> portFourLock_q[3:0] == 4'h7)
      else $error("wrong chip enable pin count");
   ce_unlisted_a: assert property (
      ceCode inside {3'b001, 3'b010, 3'b011} |=> portFourLock_q[3:0] == 4'h0)
      else $error("unlisted code took pins");
   addr_pins_a: assert property (
      addrCode == 3'b011 |=> portFourLock_q[7:4] == 4'h7 && portSixLock_q[5:4] == 2'h0)
      else $error("wrong address pin count");
   small_block_a: assert property (
      busStrobe && !busIsData && addrCode == 3'b000 && busAddr == 24'h008000
         |=> progCe_n_q == 8'hfd)
      else $error("32kB block decode wrong");
   big_block_a: assert property (
      busStrobe && !busIsData && addrCode == 3'b110 && busAddr == 24'hc00000
         |=> progCe_n_q == 8'hf7)
      else $error("4MB block decode wrong");
   idle_ce_a: assert property (
      !busStrobe |=> progCe_n_q == 8'hff && periphCe_n_q == 4'hf)
      else $error("chip enable without cycle");
   combined_a: assert property (
      memCtrl[0] |=> periphCe_n_q[0])
      else $error("combined peripheral enable still driven");
   covered_a: assert property (
      busStrobe && busIsData && |(progDec.hit & memCtrlTwo) |=> periphCe_n_q == 4'hf)
      else $error("peripheral enable on covered area");
   lock_a: assert property (
      ceLoMask[0] && $changed(portFourLatch[0]) && $stable(progSel[0])
         |=> portFourOut_q[0] == ~$past(progSel[0]))
      else $error("locked pin follows latch");
   hi_ce_pins_a: assert property (
      secondPortCfg[2:0] == 3'b111 |=> portSixLock_q[3:0] == 4'hf)
      else $error("enables four to seven not on pins");

endmodule : emcd_pin_mux

// ---- verilog/emcd_cfg.svh ----
// Purpose: Offsets-free constants for the external memory chip-enable decoder
// Assumes: Included by bare name from the design modules
// Notes:   Codes are the values of the config register fields
`ifndef EMCD_CFG_SVH
`define EMCD_CFG_SVH

`define EMCD_CFG_RESET      8'hff
`define EMCD_ADDR_LSB       3
`define EMCD_ADDR_MSB       5
`define EMCD_CE_LSB         0
`define EMCD_CE_MSB         2
`define EMCD_TA_KEY_ONE     8'haa
`define EMCD_TA_KEY_TWO     8'h55
`define EMCD_TA_WINDOW_NS   120
`define EMCD_CLK_PERIOD_NS  40
`define EMCD_TA_WINDOW_CYC  (`EMCD_TA_WINDOW_NS / `EMCD_CLK_PERIOD_NS)
`define EMCD_SHIFT_32K      5'h0f
`define EMCD_SHIFT_128K     5'h11
`define EMCD_SHIFT_256K     5'h12
`define EMCD_SHIFT_512K     5'h13
`define EMCD_SHIFT_1M       5'h14
`define EMCD_SHIFT_2M       5'h15
`define EMCD_SHIFT_4M       5'h16

`endif

// ---- verilog/emcd_pkg.sv ----
// Purpose: Types shared by the chip-enable decoder modules
// Assumes: Constants live in emcd_cfg.svh
// Notes:   Nothing is imported; users write emcd_pkg::name
package emcd_pkg;

   typedef enum logic [1:0] {
      TA_IDLE  = 2'b00,
      TA_ARMED = 2'b01,
      TA_OPEN  = 2'b10
   } emcd_ta_type;

   typedef logic [23:0] emcd_addr_type;

endpackage : emcd_pkg

// ---- verilog/emcd_dec_if.sv ----
// Purpose: Carries one address and a size code to a block decoder
// Assumes: Same clock domain on both sides
// Notes:   hit is combinational from the decoder
`timescale 1ns/100ps
interface emcd_dec_if;
   emcd_pkg::emcd_addr_type addr;
   logic [2:0]              sizeCode;
   logic [7:0]              hit;

   modport requester (output addr, output sizeCode, input hit);
   modport decoder   (input addr, input sizeCode, output hit);
endinterface : emcd_dec_if

// ---- verilog/emcd_block_decode.sv ----
// Purpose: Decodes which of eight consecutive blocks an address falls in
// Assumes: Block size follows the upper address field code
// Notes:   Index beyond 7 hits nothing
`timescale 1ns/100ps
`include "emcd_cfg.svh"
module emcd_block_decode (
   // Decode request
   emcd_dec_if.decoder dec
);

   function automatic logic [4:0] blockShift(input logic [2:0] code);
      case (code)
         3'b000:  blockShift = `EMCD_SHIFT_32K;
         3'b001:  blockShift = `EMCD_SHIFT_128K;
         3'b010:  blockShift = `EMCD_SHIFT_256K;
         3'b011:  blockShift = `EMCD_SHIFT_512K;
         3'b100:  blockShift = `EMCD_SHIFT_1M;
         3'b101:  blockShift = `EMCD_SHIFT_2M;
         default: blockShift = `EMCD_SHIFT_4M;
      endcase
   endfunction : blockShift

   emcd_pkg::emcd_addr_type blockIdx;

   always_comb begin
      blockIdx = dec.addr >> blockShift(dec.sizeCode);
      dec.hit  = 8'h00;
      // With 4MB blocks a 24-bit address only reaches index 3
      if (blockIdx < 24'h000008) begin
         dec.hit[blockIdx[2:0]] = 1'b1;
      end
   end

endmodule : emcd_block_decode

// ---- sim/emcd_mem_model.sv ----
// Purpose: External program/data memories hanging off the chip enables
// Assumes: Enables are active low and sampled on sys_clk
// Notes:   Flags any cycle where two devices would drive the bus at once
`timescale 1ns/100ps
module emcd_mem_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   // Enables from the decoder
   input  wire logic [7:0] progCe_n_q,
   input  wire logic [3:0] periphCe_n_q,
   // Status
   output logic            multiSel_q
);
   logic [3:0] selCount;

   // Overlapping blocks would make two memories fight on the data bus
   always_comb begin
      selCount = 4'h0;
      for (int i = 0; i < 8; i++) begin
         selCount = selCount + {3'h0, ~progCe_n_q[i]};
      end
      for (int i = 0; i < 4; i++) begin
         selCount = selCount + {3'h0, ~periphCe_n_q[i]};
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         multiSel_q <= 1'b0;
      end else if (selCount > 4'h1) begin
         multiSel_q <= 1'b1;
      end
   end
endmodule : emcd_mem_model

// ---- sim/ext_mem_chip_enable_decoder_tb.sv ----
// Purpose: Self-checking bench for the pin mux and chip-enable decoder
// Assumes: Inputs change on the falling edge
// Notes:   Enable pin values are checked once against the bus address
`timescale 1ns/100ps
module ext_mem_chip_enable_decoder_tb;
   typedef struct {
      logic [7:0]  cfg;
      logic [23:0] addr;
      logic [7:0]  ce;
      logic [7:0]  l4;
      logic [5:0]  l6;
   } emcd_row_type;

   logic        sys_clk, rst_b, cfgWr, taWr, taOpen_q, busStrobe, busIsData, multiSel_q;
   logic [7:0]  cfgWrData, taWrData, cfgRdData_q, memCtrl, memCtrlTwo, secondPortCfg;
   logic [7:0]  portFourLatch, portFourOut_q, portFourLock_q, progCe_n_q;
   logic [5:0]  portSixLatch, portSixOut_q, portSixLock_q;
   logic [3:0]  periphCe_n_q;
   logic [23:0] busAddr;
   int          errTotal, checksDone;
   emcd_row_type rows [9] = '{
      '{8'h00, 24'h038000, 8'h7f, 8'h00, 6'h00},
      '{8'h07, 24'h040000, 8'hff, 8'h0f, 6'h00},
      '{8'h09, 24'h020000, 8'hfd, 8'h10, 6'h00},
      '{8'h12, 24'h1c0000, 8'h7f, 8'h30, 6'h00},
      '{8'h1b, 24'h080000, 8'hfd, 8'h70, 6'h00},
      '{8'h24, 24'h300000, 8'hf7, 8'hf1, 6'h00},
      '{8'h2d, 24'he00000, 8'h7f, 8'hf3, 6'h10},
      '{8'h36, 24'hc00000, 8'hf7, 8'hf7, 6'h30},
      '{8'h3f, 24'h400000, 8'hfd, 8'hff, 6'h30}};

   emcd_pin_mux dut (.sys_clk(sys_clk), .rst_b(rst_b), .cfgWr(cfgWr), .cfgWrData(cfgWrData),
      .taWr(taWr), .taWrData(taWrData), .cfgRdData_q(cfgRdData_q), .taOpen_q(taOpen_q),
      .memCtrl(memCtrl), .memCtrlTwo(memCtrlTwo), .secondPortCfg(secondPortCfg),
      .busStrobe(busStrobe), .busIsData(busIsData), .busAddr(busAddr),
      .portFourLatch(portFourLatch), .portSixLatch(portSixLatch),
      .portFourOut_q(portFourOut_q), .portFourLock_q(portFourLock_q),
      .portSixOut_q(portSixOut_q), .portSixLock_q(portSixLock_q),
      .progCe_n_q(progCe_n_q), .periphCe_n_q(periphCe_n_q));

   emcd_mem_model mem (.sys_clk(sys_clk), .rst_b(rst_b), .progCe_n_q(progCe_n_q),
      .periphCe_n_q(periphCe_n_q), .multiSel_q(multiSel_q));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic finishTest;
      $display("checks %0d mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finishTest

   // Key one then key two on consecutive edges; taWr is left high
   task automatic unlock(input logic [7:0] key2);
      @(negedge sys_clk) taWr = 1'b1;
      taWrData = 8'haa;
      @(negedge sys_clk) taWrData = key2;
   endtask : unlock

   // Key sequence then the write, back to back
   task automatic cfgWrite(input logic [7:0] d, input logic [7:0] key2);
      unlock(key2);
      @(negedge sys_clk) taWr = 1'b0;
      cfgWr = 1'b1;
      cfgWrData = d;
      @(negedge sys_clk) cfgWr = 1'b0;
   endtask : cfgWrite

   // Outputs are registered, so they are read one cycle after the strobe
   task automatic access(input logic [23:0] a, input logic isData);
      @(negedge sys_clk) busStrobe = 1'b1;
      busAddr = a;
      busIsData = isData;
      @(negedge sys_clk) busStrobe = 1'b0;
   endtask : access

   initial begin
      {cfgWr, taWr, busStrobe, busIsData, rst_b} = 5'h00;
      {cfgWrData, taWrData, memCtrl, memCtrlTwo, secondPortCfg} = '0;
      busAddr = 24'h000000;
      portFourLatch = 8'hff;
      portSixLatch = 6'h3f;
      errTotal = 0;
      checksDone = 0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(cfgRdData_q, 8'hff);
      chk({portSixLock_q[5:4], portFourLock_q}, 10'h3ff);
      chk(progCe_n_q, 8'hff);
      cfgWrite(8'h00, 8'h56);
      chk(cfgRdData_q, 8'hff);
      @(negedge sys_clk) cfgWr = 1'b1;
      @(negedge sys_clk) cfgWr = 1'b0;
      chk(cfgRdData_q, 8'hff);
      // Window left open: a write at its last edge lands, one edge later it is refused
      unlock(8'h55);
      @(negedge sys_clk) taWr = 1'b0;
      @(negedge sys_clk) chk(taOpen_q, 1'b1);
      @(negedge sys_clk);
      @(negedge sys_clk) cfgWr = 1'b1;
      cfgWrData = 8'h2d;
      @(negedge sys_clk) cfgWr = 1'b0;
      chk(cfgRdData_q, 8'h2d);
      unlock(8'h55);
      @(negedge sys_clk) taWr = 1'b0;
      repeat (4) @(negedge sys_clk);
      cfgWr = 1'b1;
      cfgWrData = 8'h12;
      @(negedge sys_clk) cfgWr = 1'b0;
      chk(cfgRdData_q, 8'h2d);
      chk(taOpen_q, 1'b0);
      $display("reset and lock test done");
      foreach (rows[i]) begin
         cfgWrite(rows[i].cfg, 8'h55);
         chk(cfgRdData_q, rows[i].cfg);
         access(rows[i].addr, 1'b0);
         chk(progCe_n_q, rows[i].ce);
         chk(portFourLock_q, rows[i].l4);
         chk(portSixLock_q, rows[i].l6);
      end
      $display("table test done");
      // Address pins follow the bus, not the latches
      portFourLatch = 8'h00;
      portSixLatch = 6'h00;
      access(24'h2a0000, 1'b0);
      chk(portFourOut_q[7:4], 4'ha);
      chk(portSixOut_q[5:4], 2'b10);
      chk(portSixOut_q[3:0], 4'h0);
      chk(portFourOut_q[3:0], 4'he);
      $display("pin value test done");
      cfgWrite(8'h07, 8'h55);
      access(24'h008000, 1'b0);
      chk(progCe_n_q, 8'hfd);
      memCtrlTwo = 8'h02;
      access(24'h008000, 1'b1);
      chk({progCe_n_q, periphCe_n_q}, 12'hfdf);
      access(24'h010000, 1'b1);
      chk({progCe_n_q, periphCe_n_q}, 12'hffb);
      secondPortCfg = 8'h08;
      access(24'h010000, 1'b1);
      chk({progCe_n_q, periphCe_n_q}, 12'hffe);
      secondPortCfg = 8'h07;
      memCtrl = 8'h05;
      access(24'h010000, 1'b1);
      chk({progCe_n_q, periphCe_n_q}, 12'hfbf);
      access(24'h020000, 1'b0);
      chk(progCe_n_q, 8'hef);
      chk(portSixLock_q[3:0], 4'hf);
      chk(multiSel_q, 1'b0);
      $display("data access test done");
      // Reset in mid-run brings the register back to all ones
      @(negedge sys_clk) rst_b = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk(cfgRdData_q, 8'hff);
      chk({portSixLock_q, portFourLock_q}, 14'h3fff);
      chk(taOpen_q, 1'b0);
      chk(progCe_n_q, 8'hff);
      $display("mid-run reset test done");
      finishTest();
   end

   initial begin
      #(40 * 2000);
      errTotal++;
      finishTest();
   end
endmodule : ext_mem_chip_enable_decoder_tb
